/* logic/ohi_pkg.sv */
// Shared constants for both ends of the display module host port.
package ohi_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETUP_NS = 5;
  localparam int WR_PULSE_NS = 45;
  localparam int RD_PULSE_NS = 90;
  localparam int SCL_PULSE_NS = 90;
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WR_PULSE_CYC = 4'((WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RD_PULSE_CYC = 4'((RD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] SCL_PULSE_CYC = 4'((SCL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SER_SCL_BIT = 0;
  localparam int SER_SDI_BIT = 1;
  localparam int SER_SDO_BIT = 2;
  localparam int SER_RW_BIT = 3;
  localparam logic [7:0] SER_HOST_OE = 8'h0B;
  localparam logic [7:0] SER_DEV_OE = 8'h04;
  localparam logic [7:0] PAR_OE = 8'hFF;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int BUF_DEPTH = 2;
endpackage

/* logic/ohi_if.sv */
// Pin bundle between the host and the display module, with bus resolution.
interface ohi_if;
  logic csN;
  logic dcSel;
  logic wrSel;
  logic rdEn;
  logic busTypeSel;
  logic cpuTypeSel;
  logic moduleResetN;
  logic panelSupplyOn;
  logic [7:0] hostOut;
  logic [7:0] hostOe;
  logic [7:0] devOut;
  logic [7:0] devOe;
  logic [7:0] hostDataLines;

  // Undriven lines read low, as the unused serial lines are tied to ground.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      hostDataLines[i] = hostOe[i] ? hostOut[i] : (devOe[i] ? devOut[i] : 1'b0);
    end
  end

  modport host (
    output csN, dcSel, wrSel, rdEn, busTypeSel, cpuTypeSel, moduleResetN, panelSupplyOn,
    output hostOut, hostOe,
    input hostDataLines
  );
  modport device (
    input csN, dcSel, wrSel, rdEn, busTypeSel, cpuTypeSel, moduleResetN, panelSupplyOn,
    output devOut, devOe,
    input hostDataLines
  );
endinterface

/* logic/ohi_device.sv */
// Display module end: decodes parallel and serial host transfers into bytes.
//
// Behaviour
// - bus-type strap low serial, high parallel.
// - ignore all bus activity unless selected.
// - module reset low initialises the controller.
// - data/command high means display data.
// - data/command low means command register byte.
// - 80xx mode: first strobe pin writes, low.
// - 80xx mode: second strobe pin reads, low.
// - 68xx host drives read/write select level.
// - 68xx transfer only while enable high, selected.
// - parallel mode uses eight-bit bidirectional bus.
// - serial lines are clock, in, out, direction.
// - host grounds unused data lines in serial; the host leaves them undriven and the link reads them low.
// - supply control input switches panel supply.
module ohi_device
  import ohi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Host link.
  ohi_if.device bus,
  // Received bytes.
  output logic rxValid_q,
  output logic [7:0] rxByte_q,
  output logic rxIsData_q,
  // Readback byte and module controls.
  input wire logic [7:0] rdData,
  output logic ctrlInit_q,
  output logic panelPower_q
);
  logic csNQ;
  logic dcQ;
  logic wrSelQ;
  logic wrSelP;
  logic rdEnQ;
  logic rdEnP;
  logic parQ;
  logic m68Q;
  logic resNQ;
  logic supQ;
  logic [7:0] dataQ;
  logic sclP;
  logic [2:0] bitCnt_q;
  logic [7:0] rxShift_q;
  logic [7:0] txShift_q;
  logic [7:0] devOut_q;
  logic [7:0] devOe_q;
  logic sel;
  logic wr80;
  logic wr68;
  logic rd80;
  logic rd68;
  logic sclRise;
  logic sclFall;
  logic serRead;

  // Pins are synchronous to clk_sys, so one sampling stage suffices.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      csNQ <= 1'b1;
      dcQ <= 1'b0;
      wrSelQ <= 1'b1;
      wrSelP <= 1'b1;
      rdEnQ <= 1'b1;
      rdEnP <= 1'b1;
      parQ <= 1'b0;
      m68Q <= 1'b0;
      resNQ <= 1'b0;
      supQ <= 1'b0;
      dataQ <= DATA_RST;
      sclP <= 1'b0;
    end
    else
    begin
      csNQ <= bus.csN;
      dcQ <= bus.dcSel;
      wrSelQ <= bus.wrSel;
      wrSelP <= wrSelQ;
      rdEnQ <= bus.rdEn;
      rdEnP <= rdEnQ;
      parQ <= bus.busTypeSel;
      m68Q <= bus.cpuTypeSel;
      resNQ <= bus.moduleResetN;
      supQ <= bus.panelSupplyOn;
      dataQ <= bus.hostDataLines;
      sclP <= dataQ[SER_SCL_BIT];
    end
  end

  always_comb
  begin
    sel = !csNQ && resNQ;
    wr80 = sel && parQ && !m68Q && !wrSelP && wrSelQ;
    wr68 = sel && parQ && m68Q && !wrSelQ && rdEnP && !rdEnQ;
    rd80 = sel && parQ && !m68Q && !rdEnQ;
    rd68 = sel && parQ && m68Q && wrSelQ && rdEnQ;
    sclRise = sel && !parQ && !sclP && dataQ[SER_SCL_BIT];
    sclFall = sel && !parQ && sclP && !dataQ[SER_SCL_BIT];
    serRead = sel && !parQ && dataQ[SER_RW_BIT];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || !sel || parQ)
    begin
      bitCnt_q <= 3'h0;
      rxShift_q <= DATA_RST;
      txShift_q <= rdData;
    end
    else if (sclRise)
    begin
      bitCnt_q <= bitCnt_q + 3'h1;
      rxShift_q <= {rxShift_q[6:0], dataQ[SER_SDI_BIT]};
    end
    else if (sclFall)
    begin
      txShift_q <= {txShift_q[6:0], 1'b0};
    end
    else if (bitCnt_q == 3'h0)
    begin
      txShift_q <= rdData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxValid_q <= 1'b0;
      rxByte_q <= DATA_RST;
      rxIsData_q <= 1'b0;
    end
    else if (wr80 || wr68)
    begin
      rxValid_q <= 1'b1;
      rxByte_q <= dataQ;
      rxIsData_q <= dcQ;
    end
    else if (sclRise && bitCnt_q == LAST_BIT && !serRead)
    begin
      rxValid_q <= 1'b1;
      rxByte_q <= {rxShift_q[6:0], dataQ[SER_SDI_BIT]};
      rxIsData_q <= dcQ;
    end
    else
    begin
      rxValid_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      devOut_q <= DATA_RST;
      devOe_q <= DATA_RST;
    end
    else if (rd80 || rd68)
    begin
      devOut_q <= rdData;
      devOe_q <= PAR_OE;
    end
    else if (serRead)
    begin
      devOut_q <= {5'h00, txShift_q[7], 2'h0};
      devOe_q <= SER_DEV_OE;
    end
    else
    begin
      devOut_q <= DATA_RST;
      devOe_q <= DATA_RST;
    end
  end

  assign bus.devOut = devOut_q;
  assign bus.devOe = devOe_q;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrlInit_q <= 1'b1;
      panelPower_q <= 1'b0;
    end
    else
    begin
      ctrlInit_q <= !resNQ;
      panelPower_q <= supQ;
    end
  end
endmodule // ohi_device

/* logic/ohi_host.sv */
// Host end: queues byte requests and plays them out on the module's pins.
module ohi_host
  import ohi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Link configuration and module controls.
  input wire logic busTypeSel,
  input wire logic cpuTypeSel,
  input wire logic resetReq,
  input wire logic supplyOn,
  // Requests.
  input wire logic reqValid,
  output logic reqReady_q,
  input wire logic reqRead,
  input wire logic reqIsData,
  input wire logic [7:0] reqByte,
  // Read answers.
  output logic rspValid_q,
  output logic [7:0] rspByte_q,
  // Module pins.
  ohi_if.host bus
);
  typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, SLOW, SHIGH, FIN} ohi_hstate_t;

  ohi_hstate_t state_q;
  logic [9:0] buf_q [BUF_DEPTH];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic push;
  logic pop;
  logic [9:0] cur_q;
  logic [3:0] cnt_q;
  logic [2:0] bitIdx_q;
  logic csN_q;
  logic dc_q;
  logic wrSel_q;
  logic rdEn_q;
  logic bus_q;
  logic cpu_q;
  logic resN_q;
  logic sup_q;
  logic [7:0] out_q;
  logic [7:0] oe_q;
  logic [3:0] pulse;

  // Two-entry buffer; the engine pops only when idle, so it back-pressures.
  always_comb
  begin
    push = reqValid && reqReady_q;
    pop = (state_q == IDLE) && (count_q != 2'h0);
    count_d = count_q + {1'b0, push} - {1'b0, pop};
    pulse = cur_q[9] ? RD_PULSE_CYC : WR_PULSE_CYC;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
      reqReady_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_q[wrPtr_q] <= {reqRead, reqIsData, reqByte};
        wrPtr_q <= !wrPtr_q;
      end
      if (pop)
      begin
        rdPtr_q <= !rdPtr_q;
      end
      count_q <= count_d;
      reqReady_q <= count_d < 2'(BUF_DEPTH);
    end
  end

  // Straps and module controls follow the configuration inputs.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_q <= 1'b0;
      cpu_q <= 1'b0;
      resN_q <= 1'b0;
      sup_q <= 1'b0;
    end
    else
    begin
      bus_q <= busTypeSel;
      cpu_q <= cpuTypeSel;
      resN_q <= !resetReq;
      sup_q <= supplyOn;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= IDLE;
      cur_q <= 10'h000;
      cnt_q <= 4'h0;
      bitIdx_q <= 3'h0;
      csN_q <= 1'b1;
      dc_q <= 1'b0;
      wrSel_q <= 1'b1;
      rdEn_q <= 1'b1;
      out_q <= DATA_RST;
      oe_q <= DATA_RST;
      rspValid_q <= 1'b0;
      rspByte_q <= DATA_RST;
    end
    else
    begin
      rspValid_q <= 1'b0;
      unique case (state_q)
        IDLE:
        begin
          wrSel_q <= 1'b1;
          rdEn_q <= !cpu_q;
          if (pop)
          begin
            cur_q <= buf_q[rdPtr_q];
            csN_q <= 1'b0;
            dc_q <= buf_q[rdPtr_q][8];
            cnt_q <= SETUP_CYC - 4'h1;
            state_q <= SETUP;
            if (!bus_q)
            begin
              out_q <= {4'h0, buf_q[rdPtr_q][9], 3'h0};
              oe_q <= SER_HOST_OE;
            end
            else
            begin
              out_q <= buf_q[rdPtr_q][7:0];
              oe_q <= buf_q[rdPtr_q][9] ? DATA_RST : PAR_OE;
              wrSel_q <= cpu_q ? buf_q[rdPtr_q][9] : 1'b1;
            end
          end
        end
        SETUP:
        begin
          if (cnt_q != 4'h0)
          begin
            cnt_q <= cnt_q - 4'h1;
          end
          else if (!bus_q)
          begin
            bitIdx_q <= LAST_BIT;
            out_q[SER_SDI_BIT] <= cur_q[LAST_BIT];
            cnt_q <= SCL_PULSE_CYC - 4'h1;
            state_q <= SLOW;
          end
          else
          begin
            if (cpu_q)
            begin
              rdEn_q <= 1'b1;
            end
            else if (cur_q[9])
            begin
              rdEn_q <= 1'b0;
            end
            else
            begin
              wrSel_q <= 1'b0;
            end
            cnt_q <= pulse - 4'h1;
            state_q <= LOW;
          end
        end
        LOW:
        begin
          if (cnt_q != 4'h0)
          begin
            cnt_q <= cnt_q - 4'h1;
          end
          else
          begin
            if (cur_q[9])
            begin
              rspByte_q <= bus.hostDataLines;
            end
            rdEn_q <= !cpu_q;
            wrSel_q <= cpu_q ? cur_q[9] : 1'b1;
            cnt_q <= pulse - 4'h1;
            state_q <= HIGH;
          end
        end
        HIGH:
        begin
          if (cnt_q != 4'h0)
          begin
            cnt_q <= cnt_q - 4'h1;
          end
          else
          begin
            state_q <= FIN;
          end
        end
        SLOW:
        begin
          if (cnt_q != 4'h0)
          begin
            cnt_q <= cnt_q - 4'h1;
          end
          else
          begin
            out_q[SER_SCL_BIT] <= 1'b1;
            cnt_q <= SCL_PULSE_CYC - 4'h1;
            state_q <= SHIGH;
          end
        end
        SHIGH:
        begin
          if (cnt_q != 4'h0)
          begin
            cnt_q <= cnt_q - 4'h1;
          end
          else
          begin
            if (cur_q[9])
            begin
              rspByte_q <= {rspByte_q[6:0], bus.hostDataLines[SER_SDO_BIT]};
            end
            out_q[SER_SCL_BIT] <= 1'b0;
            if (bitIdx_q == 3'h0)
            begin
              state_q <= FIN;
            end
            else
            begin
              bitIdx_q <= bitIdx_q - 3'h1;
              out_q[SER_SDI_BIT] <= cur_q[bitIdx_q - 3'h1];
              cnt_q <= SCL_PULSE_CYC - 4'h1;
              state_q <= SLOW;
            end
          end
        end
        FIN:
        begin
          csN_q <= 1'b1;
          oe_q <= DATA_RST;
          out_q <= DATA_RST;
          rspValid_q <= cur_q[9];
          state_q <= IDLE;
        end
      endcase
    end
  end

  assign bus.csN = csN_q;
  assign bus.dcSel = dc_q;
  assign bus.wrSel = wrSel_q;
  assign bus.rdEn = rdEn_q;
  assign bus.busTypeSel = bus_q;
  assign bus.cpuTypeSel = cpu_q;
  assign bus.moduleResetN = resN_q;
  assign bus.panelSupplyOn = sup_q;
  assign bus.hostOut = out_q;
  assign bus.hostOe = oe_q;
endmodule // ohi_host

/* test/ohi_assertions.sv */
// Pin-level checks on the link between the host end and the display end.
module ohi_assertions
  import ohi_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Control pins.
  input wire logic csN,
  input wire logic wrSel,
  input wire logic rdEn,
  input wire logic busTypeSel,
  input wire logic cpuTypeSel,
  input wire logic moduleResetN,
  // Data-line output enables.
  input wire logic [7:0] hostOe,
  input wire logic [7:0] devOe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_rd80;
    busTypeSel && !cpuTypeSel && !csN && $fell(rdEn);
  endsequence

  property p_selIdle;
    csN[*3] |-> devOe == 8'h00;
  endproperty
  property p_resetQuiet;
    (!moduleResetN)[*3] |-> devOe == 8'h00;
  endproperty
  property p_rdDrive;
    s_rd80 |-> ##[1:3] devOe == PAR_OE;
  endproperty
  property p_wrOnly;
    (busTypeSel && !cpuTypeSel && rdEn)[*4] |-> devOe == 8'h00;
  endproperty
  property p_enQuiet;
    (busTypeSel && cpuTypeSel && !rdEn)[*4] |-> devOe == 8'h00;
  endproperty
  property p_wrBus;
    busTypeSel && !cpuTypeSel && !wrSel |-> !csN && hostOe == PAR_OE;
  endproperty
  property p_noClash;
    (hostOe & devOe) == 8'h00;
  endproperty
  property p_serHost;
    !busTypeSel |-> (hostOe & ~SER_HOST_OE) == 8'h00;
  endproperty
  property p_serDev;
    (!busTypeSel)[*4] |-> (devOe & ~SER_DEV_OE) == 8'h00;
  endproperty

  a_selIdle: assert property (p_selIdle) else $error("device drives while deselected");
  a_resetQuiet: assert property (p_resetQuiet) else $error("device drives in reset");
  a_rdDrive: assert property (p_rdDrive) else $error("read strobe not answered");
  a_wrOnly: assert property (p_wrOnly) else $error("device drives without read");
  a_enQuiet: assert property (p_enQuiet) else $error("device drives enable low");
  a_wrBus: assert property (p_wrBus) else $error("write strobe without full bus");
  a_noClash: assert property (p_noClash) else $error("both ends drive one line");
  a_serHost: assert property (p_serHost) else $error("host drives unused line");
  a_serDev: assert property (p_serDev) else $error("device drives wrong serial line");
endmodule // ohi_assertions

/* test/tb_top.sv */
// Testbench joining both ends of the display host port.
module tb_top
  import ohi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic busTypeSel = 1'b0;
  logic cpuTypeSel = 1'b0;
  logic resetReq = 1'b0;
  logic supplyOn = 1'b0;
  logic reqValid = 1'b0;
  logic reqRead = 1'b0;
  logic reqIsData = 1'b0;
  logic [7:0] reqByte = 8'h00;
  logic [7:0] rdData = 8'h00;
  logic reqReady_q, rspValid_q, rxValid_q, rxIsData_q, ctrlInit_q, panelPower_q;
  logic [7:0] rspByte_q, rxByte_q;
  logic [8:0] rxQ[$];
  logic [7:0] rspQ[$];
  int numErrors = 0;
  int nTests = 0;
  int waits = 0;

  always #12.5 clk_sys = ~clk_sys;

  ohi_if ifc ();
  ohi_host u_ohi_host (.clk_sys(clk_sys), .rst(rst), .busTypeSel(busTypeSel),
    .cpuTypeSel(cpuTypeSel), .resetReq(resetReq), .supplyOn(supplyOn), .reqValid(reqValid),
    .reqReady_q(reqReady_q), .reqRead(reqRead), .reqIsData(reqIsData), .reqByte(reqByte),
    .rspValid_q(rspValid_q), .rspByte_q(rspByte_q), .bus(ifc));
  ohi_device u_ohi_device (.clk_sys(clk_sys), .rst(rst), .bus(ifc), .rxValid_q(rxValid_q),
    .rxByte_q(rxByte_q), .rxIsData_q(rxIsData_q), .rdData(rdData), .ctrlInit_q(ctrlInit_q),
    .panelPower_q(panelPower_q));
  ohi_assertions u_ohi_assertions (.clk_sys(clk_sys), .rst(rst), .csN(ifc.csN),
    .wrSel(ifc.wrSel), .rdEn(ifc.rdEn), .busTypeSel(ifc.busTypeSel),
    .cpuTypeSel(ifc.cpuTypeSel), .moduleResetN(ifc.moduleResetN), .hostOe(ifc.hostOe),
    .devOe(ifc.devOe));

  always @(posedge clk_sys)
  begin
    if (rxValid_q === 1'b1) rxQ.push_back({rxIsData_q, rxByte_q});
    if (rspValid_q === 1'b1) rspQ.push_back(rspByte_q);
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(logic [8:0] exp, logic [8:0] got);
    nTests++;
    if (got !== exp)
    begin
      numErrors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic put(logic rd, logic dc, logic [7:0] b);
    int i;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqRead <= rd;
    reqIsData <= dc;
    reqByte <= b;
    for (i = 0; i < 400; i++)
    begin
      @(posedge clk_sys);
      if (reqReady_q === 1'b1) break;
    end
    if (i > 0) waits++;
    if (i == 400)
    begin
      numErrors++;
      wrap_up();
    end
    reqValid <= 1'b0;
  endtask

  task automatic idle(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic getRx(logic [8:0] exp);
    for (int i = 0; i < 400 && rxQ.size() == 0; i++) @(posedge clk_sys);
    if (rxQ.size() == 0)
    begin
      numErrors++;
      wrap_up();
    end
    check(exp, rxQ.pop_front());
  endtask

  task automatic getRsp(logic [7:0] exp);
    for (int i = 0; i < 400 && rspQ.size() == 0; i++) @(posedge clk_sys);
    if (rspQ.size() == 0)
    begin
      numErrors++;
      wrap_up();
    end
    check({1'b0, exp}, {1'b0, rspQ.pop_front()});
  endtask

  initial
  begin
    logic [7:0] b;
    idle(8);
    rst <= 1'b0;
    supplyOn <= 1'b1;
    idle(5);
    check(9'h001, {8'h00, panelPower_q});
    supplyOn <= 1'b0;
    resetReq <= 1'b1;
    idle(5);
    check(9'h000, {8'h00, panelPower_q});
    check(9'h001, {8'h00, ctrlInit_q});
    put(1'b0, 1'b1, 8'h3C);
    idle(120);
    check(9'h000, 9'(rxQ.size()));
    resetReq <= 1'b0;
    idle(5);
    check(9'h000, {8'h00, ctrlInit_q});
    $display("test reset and supply done");
    for (int m = 0; m < 3; m++)
    begin
      busTypeSel <= (m != 0);
      cpuTypeSel <= (m == 2);
      idle(6);
      for (int dc = 0; dc < 2; dc++)
      begin
        b = 8'h96 ^ 8'(m * 3 + dc);
        put(1'b0, dc[0], b);
        getRx({dc[0], b});
      end
      rdData <= 8'hC3 ^ 8'(m);
      put(1'b1, 1'b0, 8'h00);
      getRsp(8'hC3 ^ 8'(m));
      $display("test mode %0d done", m);
    end
    waits = 0;
    for (int k = 0; k < 4; k++) put(1'b0, k[0], 8'hF0 + 8'(k));
    for (int k = 0; k < 4; k++) getRx({k[0], 8'hF0 + 8'(k)});
    check(9'h001, {8'h00, waits > 0});
    $display("test burst done");
    wrap_up();
  end
endmodule // tb_top
